//--- verilog/rcc_ctrl.sv
// reference chop control, alternate cycle insertion, gain compensation mode, fuse readout
// assumes muxSync is a one-cycle pulse at each mux cycle start, all inputs synchronous to clock
//
// The Avalon-MM slave port was decided locally.
`timescale 1ns/1ps
module rcc_ctrl #(
   parameter int AW = 16
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic [15:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic muxSync,
   input wire logic accumulationDoneEvent,
   input wire rcc_pkg::rcc_temp_t dieTempIn,
   input wire rcc_pkg::rcc_fuse_t fuseIn,
   input wire logic [AW-1:0] ampInP,
   input wire logic [AW-1:0] ampInN,
   output logic [AW-1:0] ampOutP,
   output logic [AW-1:0] ampOutN,
   output logic refChop,
   output logic altCycle,
   output logic [31:0] gainApplied
);
   import rcc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // register state
   logic ack_ff;
   logic nxt_ack;
   logic [31:0] rdata_ff;
   logic [31:0] nxt_rdata;
   logic [1:0] chopCode_ff;
   logic [1:0] nxt_chopCode;
   logic altReq_ff;
   logic nxt_altReq;
   logic accDone_ff;
   logic nxt_accDone;
   logic [31:0] gainWord_ff;
   logic [31:0] nxt_gainWord;
   logic [31:0] tempMode_ff;
   logic [31:0] nxt_tempMode;
   logic [15:0] linCoeff_ff;
   logic [15:0] nxt_linCoeff;
   logic [15:0] quadCoeff_ff;
   logic [15:0] nxt_quadCoeff;
   logic [15:0] tempRef_ff;
   logic [15:0] nxt_tempRef;
   logic [15:0] dieTemp_ff;
   logic [15:0] nxt_dieTemp;
   logic [7:0] fuseSel_ff;
   logic [7:0] nxt_fuseSel;
   // chop state
   logic refChop_ff;
   logic nxt_refChop;
   logic phase_ff;
   logic nxt_phase;
   logic altActive_ff;
   logic nxt_altActive;

   logic [13:0] idx;
   logic wrTake;
   logic rdStart;
   logic forced;
   logic [7:0] fuseMux;
   logic [31:0] gainCalc;
   logic [31:0] gainNow;
   logic [31:0] statWord;

   function automatic logic [31:0] mergeBe(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return r;
   endfunction : mergeBe

   ////////////////////////////////////////////////////////////////////////////
   // bus slave: one wait state, read data registered
   assign idx = avs_address[15:2];
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
   assign wrTake = avs_write & ack_ff;
   assign rdStart = avs_read & ~ack_ff;
   assign nxt_ack = (avs_read | avs_write) & ~ack_ff;

   always_comb begin
      unique case (fuseSel_ff) // RULE12
         FSEL_SLOPE: fuseMux = {5'h00, fuseIn.slopeFuseField};
         FSEL_BGA: fuseMux = fuseIn.bandgapFuseA;
         FSEL_BGB: fuseMux = fuseIn.bandgapFuseB;
         default: fuseMux = 8'h00;
      endcase
   end

   always_comb begin
      statWord = '0;
      statWord[STAT_CHOP_BIT] = refChop_ff;
      statWord[STAT_ALT_BIT] = altActive_ff;
      statWord[STAT_ACC_BIT] = accDone_ff;
      statWord[STAT_PHASE_BIT] = phase_ff;
   end

   always_comb begin
      nxt_rdata = rdata_ff;
      if (rdStart) begin
         unique case (idx)
            IDX_GAIN_ADJUST_WORD: nxt_rdata = gainNow;
            IDX_TEMP_MODE: nxt_rdata = tempMode_ff;
            IDX_LIN_COEFF: nxt_rdata = {16'h0000, linCoeff_ff};
            IDX_QUAD_COEFF: nxt_rdata = {16'h0000, quadCoeff_ff};
            IDX_TEMP_REF: nxt_rdata = {16'h0000, tempRef_ff};
            IDX_DIE_TEMP: nxt_rdata = {16'h0000, dieTemp_ff};
            IDX_FUSE_SEL: nxt_rdata = {24'h000000, fuseSel_ff};
            IDX_FUSE_VAL: nxt_rdata = {24'h000000, fuseMux}; // RULE12
            IDX_CHOP_CTRL: nxt_rdata = {29'h00000000, altReq_ff, chopCode_ff};
            IDX_CHOP_STAT: nxt_rdata = statWord;
            default: nxt_rdata = 32'h0000_0000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // software-written registers, plus die temperature capture from dieTempIn
   always_comb begin
      nxt_chopCode = chopCode_ff;
      nxt_gainWord = gainWord_ff;
      nxt_tempMode = tempMode_ff;
      nxt_linCoeff = linCoeff_ff;
      nxt_quadCoeff = quadCoeff_ff;
      nxt_tempRef = tempRef_ff;
      nxt_fuseSel = fuseSel_ff;
      nxt_dieTemp = dieTempIn.valid ? dieTempIn.value : dieTemp_ff;
      if (wrTake) begin
         unique case (idx)
            IDX_GAIN_ADJUST_WORD: nxt_gainWord = mergeBe(gainWord_ff, avs_writedata, avs_byteenable);
            IDX_TEMP_MODE: nxt_tempMode = mergeBe(tempMode_ff, avs_writedata, avs_byteenable);
            IDX_LIN_COEFF: nxt_linCoeff = 16'(mergeBe({16'h0000, linCoeff_ff}, avs_writedata,
                                                      avs_byteenable));
            IDX_QUAD_COEFF: nxt_quadCoeff = 16'(mergeBe({16'h0000, quadCoeff_ff}, avs_writedata,
                                                        avs_byteenable));
            IDX_TEMP_REF: nxt_tempRef = 16'(mergeBe({16'h0000, tempRef_ff}, avs_writedata,
                                                    avs_byteenable));
            IDX_FUSE_SEL: begin
               if (avs_byteenable[0]) begin
                  nxt_fuseSel = avs_writedata[7:0]; // RULE12
               end
            end
            IDX_CHOP_CTRL: begin
               if (avs_byteenable[0]) begin
                  nxt_chopCode = avs_writedata[CTRL_CODE_LSB +: 2];
               end
            end
            default: ;
         endcase
      end
   end

   // request bit: set by write of one, cleared when the alternate cycle starts; set wins
   logic altSet;
   logic accClr;
   assign altSet = wrTake & (idx == IDX_CHOP_CTRL) & avs_byteenable[0] & avs_writedata[CTRL_ALT_BIT];
   assign accClr = wrTake & (idx == IDX_CHOP_STAT) & avs_byteenable[0] & avs_writedata[STAT_ACC_BIT];

   always_comb begin
      nxt_altReq = altReq_ff;
      if (muxSync) begin
         nxt_altReq = 1'b0;
      end
      if (altSet) begin
         nxt_altReq = 1'b1; // RULE4
      end
      nxt_accDone = accDone_ff;
      if (accClr) begin
         nxt_accDone = 1'b0;
      end
      if (accumulationDoneEvent) begin
         nxt_accDone = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // chop polarity, decided only at the mux cycle boundary
   assign forced = (chopCode_ff == CHOP_POS) | (chopCode_ff == CHOP_REV);

   always_comb begin
      nxt_refChop = refChop_ff;
      nxt_phase = phase_ff;
      nxt_altActive = altActive_ff;
      if (muxSync) begin // RULE13
         // code sampled here covers the whole cycle, so late writes never split one
         nxt_altActive = altReq_ff; // RULE4
         if (forced) begin
            nxt_refChop = (chopCode_ff == CHOP_REV); // RULE2 RULE8
         end else if (altReq_ff) begin
            nxt_refChop = 1'b0; // RULE5
         end else begin
            nxt_refChop = ~phase_ff; // RULE1
            nxt_phase = ~phase_ff; // RULE1
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // gain compensation
   rcc_gain_calc #(
      .CW(16)
   ) u_gain (
      .clock(clock),
      .rst(rst),
      .dieTemp(dieTemp_ff),
      .refTemp(tempRef_ff),
      .linCoeff(linCoeff_ff),
      .quadCoeff(quadCoeff_ff),
      .gainOut(gainCalc)
   );

   // only mode 0 computes internally; any other mode keeps the processor word
   assign gainNow = (tempMode_ff == MODE_INTERNAL) ? gainCalc : gainWord_ff; // RULE10 RULE11
   assign gainApplied = gainNow;

   rcc_chop_swap #(
      .W(AW)
   ) u_swap (
      .clock(clock),
      .rst(rst),
      .swap(refChop_ff),
      .inP(ampInP),
      .inN(ampInN),
      .outP(ampOutP),
      .outN(ampOutN)
   );

   ////////////////////////////////////////////////////////////////////////////
   // state registers
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ack_ff <= 1'b0;
         rdata_ff <= RST_WORD;
         chopCode_ff <= RST_CHOP_CODE;
         altReq_ff <= 1'b0;
         accDone_ff <= 1'b0;
         gainWord_ff <= RST_WORD;
         tempMode_ff <= RST_WORD;
         linCoeff_ff <= 16'h0000;
         quadCoeff_ff <= 16'h0000;
         tempRef_ff <= 16'h0000;
         dieTemp_ff <= 16'h0000;
         fuseSel_ff <= RST_FUSE_SEL;
         refChop_ff <= 1'b0;
         phase_ff <= 1'b0;
         altActive_ff <= 1'b0;
      end else begin
         ack_ff <= nxt_ack;
         rdata_ff <= nxt_rdata;
         chopCode_ff <= nxt_chopCode;
         altReq_ff <= nxt_altReq;
         accDone_ff <= nxt_accDone;
         gainWord_ff <= nxt_gainWord;
         tempMode_ff <= nxt_tempMode;
         linCoeff_ff <= nxt_linCoeff;
         quadCoeff_ff <= nxt_quadCoeff;
         tempRef_ff <= nxt_tempRef;
         dieTemp_ff <= nxt_dieTemp;
         fuseSel_ff <= nxt_fuseSel;
         refChop_ff <= nxt_refChop;
         phase_ff <= nxt_phase;
         altActive_ff <= nxt_altActive;
      end
   end

   assign avs_readdata = rdata_ff;
   assign refChop = refChop_ff;
   assign altCycle = altActive_ff;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   property p_auto_toggle;
      @(posedge clock) disable iff (rst)
      muxSync && !forced && !altReq_ff |=> refChop_ff == !$past(phase_ff) && phase_ff != $past(phase_ff);
   endproperty
   a_auto_toggle: assert property (p_auto_toggle) else $error("auto chop did not invert"); // RULE1

   property p_forced_pos;
      @(posedge clock) disable iff (rst)
      muxSync && chopCode_ff == CHOP_POS |=> !refChop_ff;
   endproperty
   a_forced_pos: assert property (p_forced_pos) else $error("code 01 not positive"); // RULE2

   property p_forced_rev;
      @(posedge clock) disable iff (rst)
      muxSync && chopCode_ff == CHOP_REV |=> refChop_ff && $stable(phase_ff);
   endproperty
   a_forced_rev: assert property (p_forced_rev) else $error("code 10 not reversed"); // RULE2

   property p_swap;
      @(posedge clock) disable iff (rst)
      refChop_ff ##1 refChop_ff |-> ampOutP == $past(ampInN) && ampOutN == $past(ampInP);
   endproperty
   a_swap: assert property (p_swap) else $error("inputs not crossed while chop high"); // RULE3

   property p_alt_insert;
      @(posedge clock) disable iff (rst)
      muxSync && altReq_ff |=> altActive_ff && (!altReq_ff || $past(altSet));
   endproperty
   a_alt_insert: assert property (p_alt_insert) else $error("alternate cycle not inserted"); // RULE4

   property p_alt_positive;
      @(posedge clock) disable iff (rst)
      muxSync && altReq_ff && !forced |=> !refChop_ff;
   endproperty
   a_alt_positive: assert property (p_alt_positive) else $error("alternate cycle not positive"); // RULE5

   property p_hold;
      @(posedge clock) disable iff (rst)
      !muxSync |=> $stable(refChop_ff) && $stable(altActive_ff);
   endproperty
   a_hold: assert property (p_hold) else $error("polarity moved inside a cycle"); // RULE13 RULE8

   property p_mode_ext;
      @(posedge clock) disable iff (rst)
      tempMode_ff == MODE_EXTERNAL |-> gainApplied == gainWord_ff;
   endproperty
   a_mode_ext: assert property (p_mode_ext) else $error("mode 15 gain not from processor"); // RULE11

   property p_mode_int;
      @(posedge clock) disable iff (rst)
      tempMode_ff == MODE_INTERNAL && nxt_tempMode == MODE_INTERNAL && linCoeff_ff == 16'h0000
         && quadCoeff_ff == 16'h0000 |=> gainApplied == RST_WORD;
   endproperty
   a_mode_int: assert property (p_mode_int) else $error("mode 0 gain not computed"); // RULE10

   property p_fuse_read;
      @(posedge clock) disable iff (rst)
      rdStart && idx == IDX_FUSE_VAL && fuseSel_ff == FSEL_BGA |=> avs_readdata == {24'h000000, $past(fuseIn.bandgapFuseA)};
   endproperty
   a_fuse_read: assert property (p_fuse_read) else $error("fuse value read wrong"); // RULE12
endmodule : rcc_ctrl

//--- verilog/rcc_pkg.sv
// constants and carriers for the reference chop and temperature compensation control
// assumes a 32-bit avalon-mm slave with byte addresses; register index = byte address / 4
//
// Notes on behaviour
// RULE1 - codes 00 and 11 toggle chop each cycle
// RULE2 - code 01 fixed positive, 10 fixed reversed
// RULE3 - chop high swaps reference amplifier inputs
// RULE4 - alternate request inserts one alternate mux cycle
// RULE5 - alternate cycle positive unless code forced
// RULE6 - firmware requests one alternate cycle per accumulation
// RULE7 - firmware alternates forced codes after accumulation done
// RULE8 - written code rules whole next mux cycle
// RULE9 - firmware restores automatic code after two cycles
// RULE10 - mode 0: engine derives gain word itself
// RULE11 - mode 15: processor gain word is applied
// RULE12 - fuses read through select then value register
// RULE13 - polarity changes only at mux sync boundary
package rcc_pkg;
   localparam int ADDR_W = 16;
   localparam int IDX_W = 14;
   // register indices, byte address is four times the index
   localparam logic [13:0] IDX_GAIN_ADJUST_WORD = 14'h002E;
   localparam logic [13:0] IDX_TEMP_MODE = 14'h0038;
   localparam logic [13:0] IDX_LIN_COEFF = 14'h0030;
   localparam logic [13:0] IDX_QUAD_COEFF = 14'h0031;
   localparam logic [13:0] IDX_TEMP_REF = 14'h0032;
   localparam logic [13:0] IDX_DIE_TEMP = 14'h0033;
   localparam logic [13:0] IDX_FUSE_SEL = 14'h20FD;
   localparam logic [13:0] IDX_FUSE_VAL = 14'h20FF;
   localparam logic [13:0] IDX_CHOP_CTRL = 14'h2100;
   localparam logic [13:0] IDX_CHOP_STAT = 14'h2101;
   // control register fields
   localparam int CTRL_CODE_LSB = 0;
   localparam int CTRL_ALT_BIT = 2;
   // status register fields
   localparam int STAT_CHOP_BIT = 0;
   localparam int STAT_ALT_BIT = 1;
   localparam int STAT_ACC_BIT = 2;
   localparam int STAT_PHASE_BIT = 3;
   // chop codes
   localparam logic [1:0] CHOP_AUTO0 = 2'h0;
   localparam logic [1:0] CHOP_POS = 2'h1;
   localparam logic [1:0] CHOP_REV = 2'h2;
   localparam logic [1:0] CHOP_AUTO1 = 2'h3;
   // compensation modes
   localparam logic [31:0] MODE_INTERNAL = 32'h0000_0000;
   localparam logic [31:0] MODE_EXTERNAL = 32'h0000_000F;
   // fuse selector codes
   localparam logic [7:0] FSEL_SLOPE = 8'h04;
   localparam logic [7:0] FSEL_BGA = 8'h05;
   localparam logic [7:0] FSEL_BGB = 8'h06;
   // reset values
   localparam logic [1:0] RST_CHOP_CODE = 2'h3;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic [7:0] RST_FUSE_SEL = 8'h00;
   // gain arithmetic scaling
   localparam int LIN_SHIFT = 8;
   localparam int QUAD_SHIFT = 16;

   typedef struct packed {
      logic [2:0] slopeFuseField;
      logic [7:0] bandgapFuseA;
      logic [7:0] bandgapFuseB;
   } rcc_fuse_t;

   typedef struct packed {
      logic valid;
      logic [15:0] value;
   } rcc_temp_t;
endpackage : rcc_pkg

//--- verilog/rcc_gain_calc.sv
// internal gain-adjust derivation from die temperature and two coefficients
// assumes inputs held steady between die temperature updates; one cycle of latency
`timescale 1ns/1ps
module rcc_gain_calc #(
   parameter int CW = 16
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic signed [CW-1:0] dieTemp,
   input wire logic signed [CW-1:0] refTemp,
   input wire logic signed [CW-1:0] linCoeff,
   input wire logic signed [CW-1:0] quadCoeff,
   output logic [31:0] gainOut
);
   import rcc_pkg::*;

   logic signed [CW:0] delta;
   logic signed [2*CW+2:0] sq;
   logic signed [2*CW+1:0] linP;
   logic signed [3*CW+3:0] quadP;
   logic signed [3*CW+4:0] sum;
   logic [31:0] nxt_gain;
   logic [31:0] gain_ff;

   always_comb begin
      delta = (CW+1)'(dieTemp) - (CW+1)'(refTemp);
      sq = (2*CW+3)'(delta) * (2*CW+3)'(delta);
      linP = (2*CW+2)'(linCoeff) * (2*CW+2)'(delta);
      quadP = (3*CW+4)'(quadCoeff) * (3*CW+4)'(sq);
      // quadratic term scaled harder so small coefficients stay meaningful
      sum = (3*CW+5)'(linP >>> LIN_SHIFT) + (3*CW+5)'(quadP >>> QUAD_SHIFT);
      nxt_gain = sum[31:0];
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         gain_ff <= RST_WORD;
      end else begin
         gain_ff <= nxt_gain;
      end
   end

   assign gainOut = gain_ff;
endmodule : rcc_gain_calc

//--- verilog/rcc_chop_swap.sv
// reference amplifier input connection, straight or crossed
// assumes swap comes from a flop that changes only at cycle boundaries
`timescale 1ns/1ps
module rcc_chop_swap #(
   parameter int W = 16
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic swap,
   input wire logic [W-1:0] inP,
   input wire logic [W-1:0] inN,
   output logic [W-1:0] outP,
   output logic [W-1:0] outN
);
   logic [W-1:0] nxt_p;
   logic [W-1:0] nxt_n;
   logic [W-1:0] p_ff;
   logic [W-1:0] n_ff;

   always_comb begin
      // crossing the inputs flips offset sign but keeps gain polarity
      nxt_p = swap ? inN : inP; // RULE3
      nxt_n = swap ? inP : inN; // RULE3
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         p_ff <= '0;
         n_ff <= '0;
      end else begin
         p_ff <= nxt_p;
         n_ff <= nxt_n;
      end
   end

   assign outP = p_ff;
   assign outN = n_ff;
endmodule : rcc_chop_swap

//--- test/rcc_ctrl_tb_top.sv
// self-checking bench for rcc_ctrl: register rows first, then chop, alternate cycle and reset cases
// assumes the avalon slave answers in its own time; every input moves just after a rising edge
`timescale 1ns/1ps
module rcc_ctrl_tb_top;
   import rcc_pkg::*;
   typedef struct packed {logic wr; logic [15:0] addr; logic [31:0] data;} rcc_row_t;
   localparam int NROWS = 20;
   localparam int LIMIT = 20000;
   localparam logic [2:0] SLOPE_V = 3'h5;
   localparam logic [7:0] BGA_V = 8'hA7;
   localparam logic [7:0] BGB_V = 8'h3C;
   localparam logic [15:0] A_SEL = {IDX_FUSE_SEL, 2'b00};
   localparam logic [15:0] A_VAL = {IDX_FUSE_VAL, 2'b00};
   localparam logic [15:0] A_CTRL = {IDX_CHOP_CTRL, 2'b00};
   localparam logic [15:0] A_STAT = {IDX_CHOP_STAT, 2'b00};
   localparam logic [15:0] A_MODE = {IDX_TEMP_MODE, 2'b00};
   localparam logic [15:0] A_GAIN = {IDX_GAIN_ADJUST_WORD, 2'b00};
   localparam logic [15:0] A_LIN = {IDX_LIN_COEFF, 2'b00};
   localparam logic [15:0] A_BAD = 16'h0100;
   logic clock, rst, avs_read, avs_write, avs_waitrequest, muxSync, accumulationDoneEvent;
   logic refChop, altCycle;
   logic [15:0] avs_address, ampInP, ampInN, ampOutP, ampOutN;
   logic [31:0] avs_writedata, avs_readdata, gainApplied;
   logic [3:0] avs_byteenable;
   rcc_temp_t dieTempIn;
   rcc_fuse_t fuseIn;
   int errCount, samplesChecked, cycleCount;
   rcc_row_t rows [NROWS];
   logic [31:0] q;
   logic a;

   rcc_ctrl #(.AW(16)) uut (.clock(clock), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .muxSync(muxSync),
      .accumulationDoneEvent(accumulationDoneEvent), .dieTempIn(dieTempIn), .fuseIn(fuseIn),
      .ampInP(ampInP), .ampInN(ampInN), .ampOutP(ampOutP), .ampOutN(ampOutN), .refChop(refChop),
      .altCycle(altCycle), .gainApplied(gainApplied));

   ////////////////////////////////////////////////////////////////////////////////
   initial clock = 1'b0;
   always #5 clock = ~clock;

   task automatic stopTest;
      $display("mismatches %0d of %0d checks", errCount, samplesChecked);
      if (errCount == 0 && samplesChecked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : stopTest

   // a hang anywhere ends here, counted as a mismatch
   always @(posedge clock) begin
      cycleCount++;
      if (cycleCount == LIMIT) begin
         errCount++;
         stopTest();
      end
   end

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      samplesChecked++;
      if (got !== exp) begin
         $display("unexpected %s expected %h seen %h", name, exp, got);
         errCount++;
      end
   endtask : chk

   // request held until waitrequest is sampled low; one idle edge after release
   task automatic bus(input logic wr, input logic [15:0] ad, input logic [31:0] d, output logic [31:0] rd);
      avs_address <= ad;
      avs_write <= wr;
      avs_read <= ~wr;
      avs_writedata <= d;
      do @(posedge clock); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clock);
   endtask : bus

   // one mux cycle start, then time for chop and amplifier outputs to settle
   task automatic syncPulse;
      muxSync <= 1'b1;
      @(posedge clock);
      muxSync <= 1'b0;
      repeat (3) @(posedge clock);
   endtask : syncPulse

   task automatic chopChk(input logic expChop, input logic expAlt);
      chk("refChop", {31'h0, expChop}, {31'h0, refChop});
      chk("altCycle", {31'h0, expAlt}, {31'h0, altCycle});
      chk("ampOutP", expChop ? 32'(ampInN) : 32'(ampInP), 32'(ampOutP));
      chk("ampOutN", expChop ? 32'(ampInP) : 32'(ampInN), 32'(ampOutN));
   endtask : chopChk

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      rows = '{'{1'b0, A_CTRL, 32'h3}, '{1'b0, A_SEL, 32'h0}, '{1'b1, A_SEL, 32'h4},
         '{1'b0, A_VAL, 32'(SLOPE_V)}, '{1'b1, A_SEL, 32'h5}, '{1'b0, A_VAL, 32'(BGA_V)},
         '{1'b1, A_SEL, 32'h6}, '{1'b0, A_VAL, 32'(BGB_V)}, '{1'b1, A_VAL, 32'hFF},
         '{1'b0, A_VAL, 32'(BGB_V)}, '{1'b1, A_SEL, 32'h7}, '{1'b0, A_VAL, 32'h0},
         '{1'b1, A_BAD, 32'hDEADBEEF}, '{1'b0, A_BAD, 32'h0}, '{1'b1, A_LIN, 32'h100},
         '{1'b1, A_MODE, 32'hF}, '{1'b1, A_GAIN, 32'h12345678}, '{1'b0, A_GAIN, 32'h12345678},
         '{1'b1, A_MODE, 32'h0}, '{1'b0, A_GAIN, 32'hA}};
      rst = 1'b1;
      avs_address = 16'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hF;
      muxSync = 1'b0;
      accumulationDoneEvent = 1'b0;
      dieTempIn = '{valid: 1'b1, value: 16'h000A};
      fuseIn = '{slopeFuseField: SLOPE_V, bandgapFuseA: BGA_V, bandgapFuseB: BGB_V};
      ampInP = 16'h1111;
      ampInN = 16'h2222;
      errCount = 0;
      samplesChecked = 0;
      cycleCount = 0;
      repeat (4) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      chk("ampOutP rst", 32'h0, 32'(ampOutP));
      @(posedge clock);
      chopChk(1'b0, 1'b0);
      // gain rows: mode 15 applies the written word, mode 0 derives 256*10>>>8
      for (int i = 0; i < NROWS; i++) begin
         bus(rows[i].wr, rows[i].addr, rows[i].data, q);
         if (!rows[i].wr) chk("row read", rows[i].data, q);
      end
      chk("gainApplied", 32'hA, gainApplied);
      // automatic toggling under both codes
      a = refChop;
      syncPulse();
      chopChk(~a, 1'b0);
      syncPulse();
      chopChk(a, 1'b0);
      bus(1'b1, A_CTRL, 32'(CHOP_AUTO0), q);
      syncPulse();
      chopChk(~a, 1'b0);
      // forced codes hold, and a mid-cycle write waits for the boundary
      bus(1'b1, A_CTRL, 32'(CHOP_REV), q);
      syncPulse();
      chopChk(1'b1, 1'b0);
      syncPulse();
      chopChk(1'b1, 1'b0);
      bus(1'b1, A_CTRL, 32'(CHOP_POS), q);
      repeat (5) @(posedge clock);
      chopChk(1'b1, 1'b0);
      syncPulse();
      chopChk(1'b0, 1'b0);
      // accumulation done sets a sticky flag that firmware clears
      accumulationDoneEvent <= 1'b1;
      @(posedge clock);
      accumulationDoneEvent <= 1'b0;
      @(posedge clock);
      bus(1'b0, A_STAT, 32'h0, q);
      chk("accDone", 32'h1, 32'(q[STAT_ACC_BIT]));
      bus(1'b1, A_STAT, 32'h4, q);
      bus(1'b0, A_STAT, 32'h0, q);
      chk("accClear", 32'h0, 32'(q[STAT_ACC_BIT]));
      // alternate cycle under the automatic code runs positive, request self-clears
      bus(1'b1, A_CTRL, 32'h7, q);
      syncPulse();
      chopChk(1'b0, 1'b1);
      bus(1'b0, A_CTRL, 32'h0, q);
      chk("ctrl", 32'h3, q);
      syncPulse();
      chk("altCycle", 32'h0, 32'(altCycle));
      // controlled chopping: reversed alternate cycle, then positive, then reversed again
      bus(1'b1, A_CTRL, 32'h6, q);
      syncPulse();
      chopChk(1'b1, 1'b1);
      bus(1'b1, A_CTRL, 32'(CHOP_POS), q);
      syncPulse();
      chopChk(1'b0, 1'b0);
      bus(1'b1, A_CTRL, 32'(CHOP_REV), q);
      syncPulse();
      chopChk(1'b1, 1'b0);
      // second reset in mid-run brings back positive chop and the automatic code
      rst <= 1'b1;
      repeat (2) @(posedge clock);
      chk("refChop rst", 32'h0, 32'(refChop));
      rst <= 1'b0;
      @(posedge clock);
      bus(1'b0, A_CTRL, 32'h0, q);
      chk("ctrl rst", 32'h3, q);
      bus(1'b1, A_CTRL, 32'(CHOP_AUTO1), q);
      stopTest();
   end
endmodule : rcc_ctrl_tb_top
